// ---- bfhrp_core.sv ----
// port-side control of a bidirectional 36-bit dual fifo: request/grant
// handshake per port, retransmit rewind per fifo, byte parity check and
// generation per port bus, plus a small control/status register file.
// assumes: fifo core supplies boundary flags and applies the rewind
// pulses; both ports share i_core_clk; all inputs are synchronous.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bfhrp_cfg.svh"

module bfhrp_core (
  input  wire logic                         i_core_clk,       // core clock, 50 MHz
  input  wire logic                         i_srst,           // sync reset, high
  input  wire logic [`BFHRP_ADDR_W-1:0]     i_addr,           // register byte address
  input  wire logic [31:0]                  i_wdata,          // register write data
  input  wire logic                         i_wr,             // register write strobe
  input  wire logic                         i_rd,             // register read strobe
  output logic      [31:0]                  o_rdata,          // read data, cycle after
  input  wire bfhrp_pkg::bfhrp_port_req_t   i_port_a,         // port a request
  input  wire bfhrp_pkg::bfhrp_port_req_t   i_port_b,         // port b request
  input  wire bfhrp_pkg::bfhrp_bound_t      i_bound_a,        // port a boundary flags
  input  wire bfhrp_pkg::bfhrp_bound_t      i_bound_b,        // port b boundary flags
  output logic                              o_ack_a,          // port a grant
  output logic                              o_ack_b,          // port b grant
  input  wire logic                         i_replay_strobe_fifo1_n, // fifo 1 replay, low
  input  wire logic                         i_replay_strobe_fifo2_n, // fifo 2 replay, low
  output logic                              o_rewind_fifo1,   // fifo 1 read ptr to 0
  output logic                              o_rewind_fifo2,   // fifo 2 read ptr to 0
  input  wire logic [35:0]                  i_pad_a,          // word on port a pins
  input  wire logic [35:0]                  i_pad_b,          // word on port b pins
  input  wire logic                         i_width_select_low,  // port b width select
  input  wire logic                         i_width_select_high, // port b width select
  output logic                              o_parity_error_flag_port_a_n, // low on error
  output logic                              o_parity_error_flag_port_b_n, // low on error
  input  wire logic [35:0]                  i_gen_in_a,       // word passing port a
  input  wire logic [35:0]                  i_gen_in_b,       // word passing port b
  output logic      [35:0]                  o_gen_out_a,      // word after generation
  output logic      [35:0]                  o_gen_out_b       // word after generation
);
  import bfhrp_pkg::*;

  localparam logic [1:0] PaceLast = 2'(`BFHRP_PACE_PERIOD - 1);

  logic [`BFHRP_CTRL_W-1:0] ctrl_q;
  logic [1:0]               perr_lat_q;
  logic [1:0]               perr_lat_d;
  logic [1:0]               ack_q;
  logic [1:0]               replay_prev_n_q;
  logic [1:0]               rewind_q;
  logic [1:0]               flag_n_q;
  logic [35:0]              gen_q [2];
  logic [31:0]              rdata_q;

  logic                     par_even;
  logic                     policy;
  logic [1:0]               gen_en;
  logic [1:0]               latch_en;
  logic [1:0]               replay_n;
  logic [1:0]               req;
  logic [1:0]               rw;
  logic [1:0]               blocked;
  logic [1:0]               in_region;
  logic [1:0]               perr_now;
  logic [3:0]               byte_mask [2];
  logic [35:0]              pad [2];
  logic [35:0]              gen_in [2];
  logic                     stat_rd;
  logic [1:0]               pace_pos [2];

  assign par_even    = ctrl_q[`BFHRP_CTRL_PAR_EVEN];
  assign policy      = ctrl_q[`BFHRP_CTRL_POLICY];
  assign gen_en      = {ctrl_q[`BFHRP_CTRL_GEN_B], ctrl_q[`BFHRP_CTRL_GEN_A]};
  assign latch_en    = {ctrl_q[`BFHRP_CTRL_LATCH_B], ctrl_q[`BFHRP_CTRL_LATCH_A]};
  assign replay_n    = {i_replay_strobe_fifo2_n, i_replay_strobe_fifo1_n};
  assign pad[0]      = i_pad_a;
  assign pad[1]      = i_pad_b;
  assign gen_in[0]   = i_gen_in_a;
  assign gen_in[1]   = i_gen_in_b;
  assign stat_rd     = i_rd && (i_addr == `BFHRP_OFS_STATUS);

  assign req = {i_port_b.req, i_port_a.req};
  assign rw  = {i_port_b.rw, i_port_a.rw};

  assign blocked   = {(i_port_b.rw ? i_bound_b.rd_empty : i_bound_b.wr_full),
                      (i_port_a.rw ? i_bound_a.rd_empty : i_bound_a.wr_full)};
  assign in_region = {(i_port_b.rw ? i_bound_b.near_empty_flag : i_bound_b.near_full_flag),
                      (i_port_a.rw ? i_bound_a.near_empty_flag : i_bound_a.near_full_flag)};

  // which bytes of the port take part in parity; port a is always full word
  // width-steered checking
  always_comb begin
    byte_mask[0] = 4'hf;
    byte_mask[1] = 4'hf;
    if (policy) begin
      case ({i_width_select_high, i_width_select_low})
        2'b01:   byte_mask[1] = 4'h3;
        2'b00:   byte_mask[1] = 4'h1;
        default: byte_mask[1] = 4'hf;
      endcase
    end
  end

  // control register: mode, generation, latching and policy bits
  // odd after reset
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ctrl_q <= `BFHRP_CTRL_RST;
    end else if (i_wr && (i_addr == `BFHRP_OFS_CTRL)) begin
      ctrl_q <= i_wdata[`BFHRP_CTRL_W-1:0];
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      bfhrp_pace_t pace_q;
      logic [3:0]  byte_err;
      logic [35:0] gen_word;
      logic [1:0]  pace_cnt;

      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          ack_q[p] <= 1'b0;
          pace_q   <= BFHRP_PACE_W1;
        end else if (!req[p] || blocked[p]) begin
          ack_q[p] <= 1'b0;
          pace_q   <= BFHRP_PACE_W1;
        end else if (in_region[p]) begin
          case (pace_q)
            BFHRP_PACE_W1: begin
              ack_q[p] <= 1'b0;
              pace_q   <= BFHRP_PACE_W2;
            end
            BFHRP_PACE_W2: begin
              ack_q[p] <= 1'b0;
              pace_q   <= BFHRP_PACE_GRANT;
            end
            BFHRP_PACE_GRANT: begin
              ack_q[p] <= 1'b1;
              pace_q   <= BFHRP_PACE_W1;
            end
            default: begin
              ack_q[p] <= 1'b0;
              pace_q   <= BFHRP_PACE_W1;
            end
          endcase
        end else begin
          ack_q[p] <= 1'b1;
          pace_q   <= BFHRP_PACE_W1;
        end
      end

      // position in the pacing period, for status only
      always_comb begin
        case (pace_q)
          BFHRP_PACE_W2:    pace_cnt = 2'd1;
          BFHRP_PACE_GRANT: pace_cnt = PaceLast;
          default:          pace_cnt = 2'd0;
        endcase
      end

      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          replay_prev_n_q[p] <= 1'b1;
          rewind_q[p]        <= 1'b0;
        end else begin
          replay_prev_n_q[p] <= replay_n[p];
          rewind_q[p]        <= replay_prev_n_q[p] && !replay_n[p];
        end
      end

      for (genvar b = 0; b < 4; b++) begin : g_byte
        assign byte_err[b] = byte_mask[p][b] && ((^pad[p][9*b +: 9]) == par_even);
        assign gen_word[9*b +: 9] = (gen_en[p] && byte_mask[p][b]) ?
          {((^gen_in[p][9*b +: 8]) == par_even), gen_in[p][9*b +: 8]} :
          gen_in[p][9*b +: 9];
      end

      assign perr_now[p] = |byte_err;

      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          gen_q[p] <= 36'h0;
        end else begin
          gen_q[p] <= gen_word;
        end
      end

      // sticky error for latched mode; a new error wins over a status read
      always_comb begin
        perr_lat_d[p] = perr_lat_q[p];
        if (stat_rd) begin
          perr_lat_d[p] = 1'b0;
        end
        if (perr_now[p]) begin
          perr_lat_d[p] = 1'b1;
        end
      end

      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          perr_lat_q[p] <= 1'b0;
        end else begin
          perr_lat_q[p] <= perr_lat_d[p];
        end
      end

      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          flag_n_q[p] <= 1'b1;
        end else if (latch_en[p]) begin
          flag_n_q[p] <= !(perr_lat_q[p] || perr_now[p]);
        end else begin
          flag_n_q[p] <= !perr_now[p];
        end
      end

      assign pace_pos[p] = pace_cnt;
    end
  endgenerate

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rdata_q <= 32'h0;
    end else if (i_rd) begin
      if (i_addr == `BFHRP_OFS_CTRL) begin
        rdata_q <= {{(32-`BFHRP_CTRL_W){1'b0}}, ctrl_q};
      end else if (i_addr == `BFHRP_OFS_STATUS) begin
        rdata_q <= {22'h0, pace_pos[1], pace_pos[0], ~replay_n, ack_q, perr_lat_q};
      end else begin
        rdata_q <= 32'h0;
      end
    end else begin
      rdata_q <= 32'h0;
    end
  end

  assign o_rdata                      = rdata_q;
  assign o_ack_a                      = ack_q[0];
  assign o_ack_b                      = ack_q[1];
  assign o_rewind_fifo1               = rewind_q[0];
  assign o_rewind_fifo2               = rewind_q[1];
  assign o_parity_error_flag_port_a_n = flag_n_q[0];
  assign o_parity_error_flag_port_b_n = flag_n_q[1];
  assign o_gen_out_a                  = gen_q[0];
  assign o_gen_out_b                  = gen_q[1];

endmodule

// ---- bfhrp_cfg.svh ----
// offsets, field positions, reset values and timing counts for the
// dual-fifo port handshake, retransmit and parity block
`ifndef BFHRP_CFG_SVH
`define BFHRP_CFG_SVH

// register offsets (byte addresses)
`define BFHRP_ADDR_W          8
`define BFHRP_OFS_CTRL        8'h00
`define BFHRP_OFS_STATUS      8'h04

// control register field positions
`define BFHRP_CTRL_PAR_EVEN   0
`define BFHRP_CTRL_GEN_A      1
`define BFHRP_CTRL_LATCH_A    2
`define BFHRP_CTRL_POLICY     9
`define BFHRP_CTRL_GEN_B      10
`define BFHRP_CTRL_LATCH_B    11
`define BFHRP_CTRL_W          12
`define BFHRP_CTRL_RST        12'h000

// status register field positions
`define BFHRP_STAT_PERR_LAT   0
`define BFHRP_STAT_ACK        2
`define BFHRP_STAT_REPLAY     4

// grant pacing inside the near-full / near-empty regions
`define BFHRP_PACE_PERIOD     3

`endif

// ---- bfhrp_pkg.sv ----
// types shared by the port handshake, retransmit and parity block
// assumes bfhrp_cfg.svh is on the include path
package bfhrp_pkg;

  // one port's transfer request, sampled at the rising clock edge
  typedef struct packed {
    logic req;        // transfer request
    logic rw;         // 1 = fifo read, 0 = fifo write
  } bfhrp_port_req_t;

  // boundary flags of the fifo written and the fifo read from this port
  typedef struct packed {
    logic wr_full;        // target fifo full
    logic near_full_flag; // target fifo inside near-full region
    logic rd_empty;       // source fifo empty
    logic near_empty_flag;// source fifo inside near-empty region
  } bfhrp_bound_t;

  // grant pacing states inside a boundary region
  typedef enum logic [2:0] {
    BFHRP_PACE_W1    = 3'b001,
    BFHRP_PACE_W2    = 3'b010,
    BFHRP_PACE_GRANT = 3'b100
  } bfhrp_pace_t;

endpackage

// ---- bfhrp_core_monitor.sv ----
// assertions on grant pacing, rewind pulses and the register read path
// assumes a bind onto bfhrp_core, all ports on i_core_clk
`timescale 1ns/1ps
module bfhrp_core_monitor (
  input wire logic                       i_core_clk,              // clock
  input wire logic                       i_srst,                  // sync reset
  input wire logic [7:0]                 i_addr,                  // reg address
  input wire logic                       i_rd,                    // read strobe
  input wire logic [31:0]                o_rdata,                 // read data
  input wire bfhrp_pkg::bfhrp_port_req_t i_port_a,                // port a request
  input wire bfhrp_pkg::bfhrp_port_req_t i_port_b,                // port b request
  input wire bfhrp_pkg::bfhrp_bound_t    i_bound_a,               // port a bounds
  input wire logic                       o_ack_a,                 // port a grant
  input wire logic                       o_ack_b,                 // port b grant
  input wire logic                       i_replay_strobe_fifo1_n, // fifo 1 replay
  input wire logic                       i_replay_strobe_fifo2_n, // fifo 2 replay
  input wire logic                       o_rewind_fifo1,          // fifo 1 rewind
  input wire logic                       o_rewind_fifo2           // fifo 2 rewind
);
  import bfhrp_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  logic rin_a;
  // read request on port a inside the near-empty region, not blocked
  assign rin_a = i_port_a.req & i_port_a.rw & i_bound_a.near_empty_flag & ~i_bound_a.rd_empty;
  a_ack_steady: assert property (i_port_a.req && !i_port_a.rw && !i_bound_a.near_full_flag
    && !i_bound_a.wr_full |=> o_ack_a) else $error("port a grant missing");
  a_ack_idle: assert property ((!i_port_a.req |=> !o_ack_a) and
    (!i_port_b.req |=> !o_ack_b)) else $error("grant without request");
  a_ack_full: assert property (i_port_a.req && !i_port_a.rw && i_bound_a.wr_full
    |=> !o_ack_a) else $error("grant on full write");
  a_ack_empty: assert property (i_port_a.req && i_port_a.rw && i_bound_a.rd_empty
    |=> !o_ack_a) else $error("grant on empty read");
  a_pace_gap: assert property ($rose(rin_a) |=> !o_ack_a [*2]) else $error("early paced grant");
  a_pace_grant: assert property ($rose(rin_a) ##1 rin_a [*2] |=> o_ack_a)
    else $error("paced grant missing");
  a_rewind_once: assert property ($fell(i_replay_strobe_fifo1_n) |=> o_rewind_fifo1
    ##1 !o_rewind_fifo1) else $error("fifo 1 rewind not one pulse");
  a_rewind_cause: assert property (o_rewind_fifo2 |-> !$past(i_replay_strobe_fifo2_n)
    && $past(i_replay_strobe_fifo2_n, 2)) else $error("fifo 2 rewind without strobe");
  a_unmapped_zero: assert property (i_rd && i_addr != 8'h00 && i_addr != 8'h04
    |=> o_rdata == 32'h0) else $error("unmapped read not zero");
  cover property (o_ack_a [*3]);
  cover property ($rose(rin_a) ##3 o_ack_a);
  cover property (o_rewind_fifo1 ##0 o_rewind_fifo2);
endmodule

// ---- bfhrp_host_model.sv ----
// host controller on one port: holds a request for a span, counts grants
// assumes the grant is registered at the edge that samples the request
`timescale 1ns/1ps
module bfhrp_host_model (
  input  wire logic                i_clk, // port clock
  input  wire logic                i_ack, // grant from device
  output bfhrp_pkg::bfhrp_port_req_t o_req  // request to device
);
  import bfhrp_pkg::*;
  initial o_req = '0;
  task automatic run(input int n, input logic rw, output int acks);
    acks = 0;
    @(posedge i_clk);
    // request held for the whole span
    o_req <= '{req: 1'b1, rw: rw};
    repeat (n) begin
      @(posedge i_clk);
      // grant counted as the access enable
      #1 if (i_ack === 1'b1) acks++;
    end
    @(posedge i_clk);
    // released direction shows the inverse, not the last value
    o_req <= '{req: 1'b0, rw: ~rw};
  endtask
endmodule

// ---- bififo_handshake_retransmit_parity_tb_top.sv ----
// self-checking bench for bfhrp_core: registers, parity, handshake, rewind
// assumes bfhrp_cfg.svh on the include path and one 50 MHz clock
`timescale 1ns/1ps
`include "bfhrp_cfg.svh"
module bififo_handshake_retransmit_parity_tb_top;
  import bfhrp_pkg::*;
  logic clk = 0, srst = 1, wr = 0, rd = 0, rt1 = 1, rt2 = 1, ws_lo = 1, ws_hi = 1;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, d, cw;
  localparam logic [35:0] GOOD = 36'h008040201;
  logic [35:0] pad_a = GOOD, pad_b = GOOD, gen_a, gen_b;
  bfhrp_bound_t bound_a = '0, bound_b = '0;
  bfhrp_port_req_t port_a, port_b;
  logic ack_a, ack_b, rw1, rw2, flag_a, flag_b;
  logic [11:0] ctrl = '0;
  int n_fail = 0, checked = 0, seed = 62992, na, nb, nr;
  always #10 clk = ~clk;
  bfhrp_core i_dut (.i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port_a(port_a), .i_port_b(port_b),
    .i_bound_a(bound_a), .i_bound_b(bound_b), .o_ack_a(ack_a), .o_ack_b(ack_b),
    .i_replay_strobe_fifo1_n(rt1), .i_replay_strobe_fifo2_n(rt2), .o_rewind_fifo1(rw1),
    .o_rewind_fifo2(rw2), .i_pad_a(pad_a), .i_pad_b(pad_b), .i_width_select_low(ws_lo),
    .i_width_select_high(ws_hi), .o_parity_error_flag_port_a_n(flag_a),
    .o_parity_error_flag_port_b_n(flag_b), .i_gen_in_a(pad_a), .i_gen_in_b(pad_b),
    .o_gen_out_a(gen_a), .o_gen_out_b(gen_b));
  bfhrp_host_model i_host_a (.i_clk(clk), .i_ack(ack_a), .o_req(port_a));
  bfhrp_host_model i_host_b (.i_clk(clk), .i_ack(ack_b), .o_req(port_b));
  task automatic conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    #1 v = rdata;
  endtask
  function automatic logic [3:0] berr(input logic [35:0] w);
    for (int i = 0; i < 4; i++) berr[i] = (^w[9*i +: 9]) == ctrl[`BFHRP_CTRL_PAR_EVEN];
  endfunction
  function automatic logic [3:0] bmask;
    bmask = 4'hf;
    if (ctrl[`BFHRP_CTRL_POLICY] && !ws_hi) bmask = ws_lo ? 4'h3 : 4'h1;
  endfunction
  function automatic logic [35:0] gen(input logic [35:0] w, input logic [3:0] m);
    gen = w;
    for (int i = 0; i < 4; i++) if (m[i]) gen[9*i+8] = (^w[9*i +: 8]) ^ ~ctrl[0];
  endfunction
  task automatic ptest(input logic [35:0] wa, input logic [35:0] wb);
    @(posedge clk); pad_a <= wa; pad_b <= wb;
    @(posedge clk); #1;
    chk("flag a", ~|berr(wa), flag_a);
    chk("flag b", ~|(berr(wb) & bmask()), flag_b);
    chk("gen a", ctrl[`BFHRP_CTRL_GEN_A] ? gen(wa, 4'hf) : wa, gen_a);
    chk("gen b", ctrl[`BFHRP_CTRL_GEN_B] ? gen(wb, bmask()) : wb, gen_b);
  endtask
  initial begin
    #100000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk); #1;
    chk("reset flags", 2'b11, {flag_a, flag_b});
    chk("reset outs", 4'h0, {ack_a, ack_b, rw1, rw2});
    for (int k = 0; k < 3; k++) begin
      cw = $random(seed);
      wreg(8'h00, cw);
      rreg(8'h00, d);
      chk("ctrl", cw[11:0], d);
    end
    wreg(8'h04, '1);
    wreg(8'h08, '1);
    rreg(8'h00, d);
    chk("ctrl kept", cw[11:0], d);
    rreg(8'h08, d);
    chk("unmapped", 32'h0, d);
    for (int m = 0; m < 16; m++) begin
      ctrl = {1'b0, m[3], m[2], 6'h0, 1'b0, m[1], m[0]};
      wreg(8'h00, {20'h0, ctrl});
      ptest('0, '1);
      for (int w = 0; w < 4; w++) begin
        // each of the four width select settings in turn, driven by the bench
        {ws_hi, ws_lo} <= w[1:0];
        repeat (4) ptest(36'({$random(seed), $random(seed)}),
                         36'({$random(seed), $random(seed)}));
      end
    end
    ctrl = 12'h804;
    wreg(8'h00, {20'h0, ctrl});
    ptest('0, '0);
    @(posedge clk); pad_a <= GOOD; pad_b <= GOOD;
    repeat (3) @(posedge clk);
    #1 chk("latched flags", 2'b00, {flag_a, flag_b});
    rreg(8'h04, d);
    chk("latched status", 10'h003, d[9:0]);
    repeat (2) @(posedge clk);
    #1 chk("cleared flags", 2'b11, {flag_a, flag_b});
    fork i_host_a.run(6, 1'b0, na); i_host_b.run(6, 1'b1, nb); join
    chk("steady grants", {8'd6, 8'd6}, {na[7:0], nb[7:0]});
    bound_a <= 4'b0001; bound_b <= 4'b0100;
    fork i_host_a.run(9, 1'b1, na); i_host_b.run(9, 1'b0, nb); join
    chk("paced grants", {8'd3, 8'd3}, {na[7:0], nb[7:0]});
    bound_a <= 4'b1000; bound_b <= 4'b0010;
    fork i_host_a.run(4, 1'b0, na); i_host_b.run(4, 1'b1, nb); join
    chk("refused grants", 16'h0, {na[7:0], nb[7:0]});
    bound_a <= 4'b0010; bound_b <= 4'b1000;
    fork i_host_a.run(4, 1'b1, na); i_host_b.run(4, 1'b0, nb); join
    chk("refused swapped", 16'h0, {na[7:0], nb[7:0]});
    nr = 0;
    // no port traffic while the strobes are low
    @(posedge clk); rt1 <= 0; rt2 <= 0;
    fork
      begin repeat (3) @(posedge clk); rt1 <= 1; rt2 <= 1; end
      repeat (6) begin @(posedge clk); #1 nr += rw1 + rw2; end
    join
    chk("rewinds", 36'd2, nr);
    conclude();
  end
endmodule
bind bfhrp_core bfhrp_core_monitor i_mon (.*);
